// ===== hw/timer_pkg.sv
// Shared constants and carrier types of the interval timer.
// Assumes a single clock domain and a 16-bit register slave port driven by on-chip logic.
package timer_pkg;

  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam int CNT_W  = 32;
  localparam int SLICES = CNT_W / DATA_W;

  // Word offsets on the 16-bit slave port.
  localparam logic [ADDR_W-1:0] OFS_STATUS      = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_CONTROL     = 4'h1;
  localparam logic [ADDR_W-1:0] OFS_PERIOD_BASE = 4'h2;
  localparam logic [ADDR_W-1:0] OFS_SNAP_BASE   = 4'h4;

  // Field positions.
  localparam int STAT_EXPIRY_BIT  = 0;
  localparam int STAT_RUNNING_BIT = 1;
  localparam int CTRL_IRQ_EN_BIT  = 0;
  localparam int CTRL_FREE_RUN_BIT = 1;
  localparam int CTRL_START_BIT   = 2;
  localparam int CTRL_STOP_BIT    = 3;

  // Reset values.
  localparam logic [CNT_W-1:0]  DEFAULT_PERIOD = 32'h0000_ffff;
  localparam logic [DATA_W-1:0] RDATA_RESET    = 16'h0000;

  typedef struct packed {
    logic              cs;
    logic              write;
    logic              read;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } bus_req_s;

  typedef struct packed {
    logic             load;
    logic             start;
    logic             stop;
    logic             free_run;
    logic [CNT_W-1:0] period;
  } counter_cmd_s;

endpackage : timer_pkg

// ===== hw/timer_counter_core.sv
// Down counter with run state, zero hold and automatic reload.
// Assumes commands arrive as single-cycle strobes from the register slave on the same clock.
module timer_counter_core #(
  parameter bit RUN_CONTROL = 1'b1
) (
  input  wire logic                    clk_i,
  input  wire logic                    reset_n_i,
  input  wire timer_pkg::counter_cmd_s cmd_i,
  output logic [timer_pkg::CNT_W-1:0]  count_o,
  output logic                         running_o,
  output logic                         zero_o
);

  typedef struct packed {
    logic [timer_pkg::CNT_W-1:0] count;
    logic                        running;
  } core_state_s;

  core_state_s state_r;
  core_state_s state_nxt;
  logic        at_zero;

  always_comb begin
    state_nxt = state_r;
    at_zero   = state_r.running && (state_r.count == '0);
    if (at_zero) begin
      // Zero is held for this one cycle, then the period is reloaded.
      state_nxt.count   = cmd_i.period;
      state_nxt.running = cmd_i.free_run;
    end else if (state_r.running) begin
      state_nxt.count = state_r.count - timer_pkg::CNT_W'(1);
    end
    if (cmd_i.start && !state_r.running) begin
      state_nxt.running = 1'b1;
    end
    if (cmd_i.stop && RUN_CONTROL) begin
      state_nxt.running = 1'b0;
    end
    if (cmd_i.load) begin
      state_nxt.count = cmd_i.period;
      if (RUN_CONTROL) begin
        state_nxt.running = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      state_r <= '{count: timer_pkg::DEFAULT_PERIOD, running: 1'b0};
    end else begin
      state_r <= state_nxt;
    end
  end

  assign count_o   = state_r.count;
  assign running_o = state_r.running;
  assign zero_o    = at_zero;

endmodule : timer_counter_core

// ===== hw/interval_timer_control.sv
// Interval timer: 16-bit register slave, control and status bits, period and snapshot words.
// Assumes a bus master on the same clock; reads answer one cycle after the request.
module interval_timer_control #(
  parameter bit                          RUN_CONTROL     = 1'b1,
  parameter bit                          WRITABLE_PERIOD = 1'b1,
  parameter logic [timer_pkg::CNT_W-1:0] FIXED_PERIOD    = timer_pkg::DEFAULT_PERIOD
) (
  input  wire logic                           CORE_CLK_I,
  input  wire logic                           RESET_N_I,
  input  wire logic                           CHIP_SELECT_I,
  input  wire logic                           WRITE_I,
  input  wire logic                           READ_I,
  input  wire logic [timer_pkg::ADDR_W-1:0]   ADDRESS_I,
  input  wire logic [timer_pkg::DATA_W-1:0]   WRITE_DATA_I,
  output logic      [timer_pkg::DATA_W-1:0]   READ_DATA_O,
  output logic                                IRQ_O
);

  localparam int CNT_W  = timer_pkg::CNT_W;
  localparam int DATA_W = timer_pkg::DATA_W;
  localparam int ADDR_W = timer_pkg::ADDR_W;
  localparam int SLICES = timer_pkg::SLICES;

  typedef struct packed {
    logic              irq_enable;
    logic              free_running_enable;
    logic              expiry_flag;
    logic [CNT_W-1:0]  period;
    logic [CNT_W-1:0]  snapshot;
    logic [DATA_W-1:0] rdata;
  } regs_s;

  regs_s                   regs_r;
  regs_s                   regs_nxt;
  timer_pkg::bus_req_s     req;
  timer_pkg::counter_cmd_s cmd;
  logic [CNT_W-1:0]        count;
  logic                    running;
  logic                    zero_event;
  logic                    wr;
  logic                    rd;

  // Slice index of a word within a block starting at base, or -1 outside it.
  function automatic int slice_of(input logic [ADDR_W-1:0] addr,
                                  input logic [ADDR_W-1:0] base);
    int idx;
    idx = -1;
    for (int i = 0; i < SLICES; i++) begin
      if (addr == base + ADDR_W'(i)) begin
        idx = i;
      end
    end
    return idx;
  endfunction : slice_of

  // Read value of one word; unmapped words and reserved bits read as zero.
  function automatic logic [DATA_W-1:0] read_word(input logic [ADDR_W-1:0] addr,
                                                  input regs_s           rg,
                                                  input logic            run);
    logic [DATA_W-1:0] word;
    int                ps;
    int                ss;
    word = '0;
    ps   = slice_of(addr, timer_pkg::OFS_PERIOD_BASE);
    ss   = slice_of(addr, timer_pkg::OFS_SNAP_BASE);
    if (addr == timer_pkg::OFS_STATUS) begin
      word[timer_pkg::STAT_EXPIRY_BIT]  = rg.expiry_flag;
      word[timer_pkg::STAT_RUNNING_BIT] = run;
    end else if (addr == timer_pkg::OFS_CONTROL) begin
      word[timer_pkg::CTRL_IRQ_EN_BIT]   = rg.irq_enable;
      word[timer_pkg::CTRL_FREE_RUN_BIT] = rg.free_running_enable;
    end else if (ps >= 0) begin
      word = rg.period[ps*DATA_W +: DATA_W];
    end else if (ss >= 0) begin
      word = rg.snapshot[ss*DATA_W +: DATA_W];
    end
    return word;
  endfunction : read_word

  assign req = '{cs: CHIP_SELECT_I, write: WRITE_I, read: READ_I,
                 addr: ADDRESS_I, wdata: WRITE_DATA_I};
  assign wr  = req.cs && req.write;
  assign rd  = req.cs && req.read;

  always_comb begin
    int ps;
    int ss;
    ps       = slice_of(req.addr, timer_pkg::OFS_PERIOD_BASE);
    ss       = slice_of(req.addr, timer_pkg::OFS_SNAP_BASE);
    regs_nxt = regs_r;
    cmd      = '{load: 1'b0, start: 1'b0, stop: 1'b0,
                 free_run: regs_r.free_running_enable, period: regs_r.period};

    if (wr && (req.addr == timer_pkg::OFS_STATUS)) begin
      // Only the expiry flag responds here, cleared by writing 0; the running bit is not writable.
      if (!req.wdata[timer_pkg::STAT_EXPIRY_BIT]) begin
        regs_nxt.expiry_flag = 1'b0;
      end
    end

    if (wr && (req.addr == timer_pkg::OFS_CONTROL)) begin
      regs_nxt.irq_enable          = req.wdata[timer_pkg::CTRL_IRQ_EN_BIT];
      regs_nxt.free_running_enable = req.wdata[timer_pkg::CTRL_FREE_RUN_BIT];
      cmd.start = req.wdata[timer_pkg::CTRL_START_BIT];
      cmd.stop  = req.wdata[timer_pkg::CTRL_STOP_BIT] && RUN_CONTROL;
    end

    if (wr && (ps >= 0)) begin
      if (WRITABLE_PERIOD) begin
        regs_nxt.period[ps*DATA_W +: DATA_W] = req.wdata;
      end
      // With a fixed period the register never changes, so this reloads it.
      cmd.load   = 1'b1;
      cmd.period = regs_nxt.period;
    end

    if (wr && (ss >= 0)) begin
      // Whole counter captured in one cycle; data ignored; core untouched.
      regs_nxt.snapshot = count;
    end

    // A reach of zero in the same cycle as a clearing write keeps the flag set.
    if (zero_event) begin
      regs_nxt.expiry_flag = 1'b1;
    end

    if (rd) begin
      regs_nxt.rdata = read_word(req.addr, regs_r, running);
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (!RESET_N_I) begin
      regs_r <= '{irq_enable: 1'b0, free_running_enable: 1'b0, expiry_flag: 1'b0,
                 period: FIXED_PERIOD, snapshot: '0,
                 rdata: timer_pkg::RDATA_RESET};
    end else begin
      regs_r <= regs_nxt;
    end
  end

  timer_counter_core #(
    .RUN_CONTROL (RUN_CONTROL)
  ) u_core (
    .clk_i     (CORE_CLK_I),
    .reset_n_i (RESET_N_I),
    .cmd_i     (cmd),
    .count_o   (count),
    .running_o (running),
    .zero_o    (zero_event)
  );

  assign READ_DATA_O = regs_r.rdata;
  // Request stays raised until the flag or the enable is cleared.
  assign IRQ_O       = regs_r.expiry_flag && regs_r.irq_enable;

endmodule : interval_timer_control

// ===== tb/timer_monitor.sv
// Concurrent checks on the timer's register port and interrupt output.
// Assumes one clock domain with a synchronous active-low reset.
module timer_monitor (
  input wire logic                         CORE_CLK_I,
  input wire logic                         RESET_N_I,
  input wire logic                         CHIP_SELECT_I,
  input wire logic                         WRITE_I,
  input wire logic                         READ_I,
  input wire logic [timer_pkg::ADDR_W-1:0] ADDRESS_I,
  input wire logic [timer_pkg::DATA_W-1:0] WRITE_DATA_I,
  input wire logic [timer_pkg::DATA_W-1:0] READ_DATA_O,
  input wire logic                         IRQ_O
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge CORE_CLK_I);
  endclocking
  default disable iff (!RESET_N_I);
  logic rd;
  logic rd_only;
  assign rd = CHIP_SELECT_I && READ_I;
  assign rd_only = rd && !WRITE_I;
  sequence ctl_wr;
    CHIP_SELECT_I && WRITE_I && ADDRESS_I == 4'h1;
  endsequence
  sequence ctl_rd;
    rd_only && ADDRESS_I == 4'h1;
  endsequence
  rdata_hold_a: assert property (!rd |=> $stable(READ_DATA_O))
    else $error("read data changed without a read");
  unmapped_zero_a: assert property (rd && ADDRESS_I > 4'h5 |=> READ_DATA_O == 16'h0)
    else $error("unmapped read not zero");
  ctrl_events_a: assert property (ctl_rd |=> READ_DATA_O[15:2] == 14'h0)
    else $error("control event bits read nonzero");
  status_resv_a: assert property (rd && ADDRESS_I == 4'h0 |=> READ_DATA_O[15:2] == 14'h0)
    else $error("status upper bits nonzero");
  irq_off_a: assert property (ctl_wr ##0 !WRITE_DATA_I[0] |=> !IRQ_O)
    else $error("interrupt while disabled");
  irq_view_a: assert property (ctl_rd |=> (IRQ_O -> READ_DATA_O[0]))
    else $error("interrupt without enable bit");
  expiry_view_a: assert property (rd_only && ADDRESS_I == 4'h0 && IRQ_O |=> READ_DATA_O[0])
    else $error("interrupt without expiry flag");
  ctrl_back_a: assert property (ctl_wr ##1 !(CHIP_SELECT_I && WRITE_I) ##1 ctl_rd
    |=> READ_DATA_O[1:0] == $past(WRITE_DATA_I[1:0], 3)) else $error("control readback wrong");
  reset_quiet_a: assert property ($rose(RESET_N_I) |-> READ_DATA_O == 16'h0 && !IRQ_O)
    else $error("outputs not cleared by reset");
endmodule : timer_monitor

bind interval_timer_control timer_monitor u_mon (.CORE_CLK_I(CORE_CLK_I),
  .RESET_N_I(RESET_N_I), .CHIP_SELECT_I(CHIP_SELECT_I), .WRITE_I(WRITE_I), .READ_I(READ_I),
  .ADDRESS_I(ADDRESS_I), .WRITE_DATA_I(WRITE_DATA_I), .READ_DATA_O(READ_DATA_O), .IRQ_O(IRQ_O));

// ===== tb/bus_master_model.sv
// Behavioural register master issuing one access at a time.
// Assumes the timer takes an access on the rising edge; this model drives at falling edges.
module bus_master_model (
  input  wire logic                         clk_i,
  output logic                              cs_o,
  output logic                              wr_o,
  output logic                              rd_o,
  output logic [timer_pkg::ADDR_W-1:0]      addr_o,
  output logic [timer_pkg::DATA_W-1:0]      wdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    cs_o = 1'h0;
    wr_o = 1'h0;
    rd_o = 1'h0;
    addr_o = 4'h0;
    wdata_o = 16'h0;
  end
  task automatic access(input logic w, input logic [3:0] a, input logic [15:0] d);
    @(negedge clk_i);
    cs_o <= 1'h1;
    wr_o <= w;
    rd_o <= !w;
    addr_o <= a;
    wdata_o <= (a == timer_pkg::OFS_CONTROL && d[3]) ? (d & 16'hfffb) : d;
    @(negedge clk_i);
    cs_o <= 1'h0;
    wr_o <= 1'h0;
    rd_o <= 1'h0;
    // Released lines show the inverse so stale values are never mistaken for data.
    addr_o <= ~a;
    wdata_o <= ~wdata_o;
  endtask : access
endmodule : bus_master_model

// ===== tb/testbench.sv
// Self-checking bench for the interval timer: register traffic, expiry timing, interrupt.
// Assumes the master model leaves one idle cycle between accesses.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'h0;
  logic        rst_n = 1'h0;
  logic        cs, wr, rd, irq, rd_seen;
  logic [3:0]  addr;
  logic [15:0] wdata, rdata, p;
  logic [15:0] exp_q[$];
  logic        fix_sel = 1'h0;
  logic        irq_f, irq_v;
  logic [15:0] rdata_f;
  localparam logic [31:0] FIX_PERIOD = 32'h0000_0006;
  int          error_cnt = 0;
  int          samples_checked = 0;
  int          n;
  always #25 clk = ~clk;
  bus_master_model m (.clk_i(clk), .cs_o(cs), .wr_o(wr), .rd_o(rd), .addr_o(addr),
    .wdata_o(wdata));
  interval_timer_control dut (.CORE_CLK_I(clk), .RESET_N_I(rst_n),
    .CHIP_SELECT_I(cs && !fix_sel), .WRITE_I(wr), .READ_I(rd), .ADDRESS_I(addr),
    .WRITE_DATA_I(wdata), .READ_DATA_O(rdata), .IRQ_O(irq));
  // Second build without run control and with a fixed period, reached while fix_sel is set.
  interval_timer_control #(.RUN_CONTROL(1'h0), .WRITABLE_PERIOD(1'h0), .FIXED_PERIOD(FIX_PERIOD))
    dut_fixed (.CORE_CLK_I(clk), .RESET_N_I(rst_n), .CHIP_SELECT_I(cs && fix_sel),
    .WRITE_I(wr), .READ_I(rd), .ADDRESS_I(addr), .WRITE_DATA_I(wdata),
    .READ_DATA_O(rdata_f), .IRQ_O(irq_f));
  assign irq_v = fix_sel ? irq_f : irq;
  task automatic check(input string what, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask : check
  task automatic rd_exp(input logic [3:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    m.access(1'h0, a, 16'h0);
  endtask : rd_exp
  task automatic wait_irq(input int e);
    n = 0;
    while (irq_v !== 1'h1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    check("expiry cycles", e, n);
  endtask : wait_irq
  task automatic summarize();
    $display("Comparisons %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : summarize
  always @(posedge clk) rd_seen <= cs && rd;
  always @(negedge clk) begin
    if (rd_seen === 1'h1) check("READ_DATA_O", exp_q.pop_front(), fix_sel ? rdata_f : rdata);
  end
  initial begin
    #100000;
    error_cnt++;
    summarize();
  end
  initial begin
    void'($urandom(99508));
    p = 16'(8 + $urandom % 8);
    repeat (5) @(negedge clk);
    rst_n <= 1'h1;
    rd_exp(timer_pkg::OFS_STATUS, 16'h0);
    rd_exp(timer_pkg::OFS_CONTROL, 16'h0);
    rd_exp(timer_pkg::OFS_PERIOD_BASE, timer_pkg::DEFAULT_PERIOD[15:0]);
    rd_exp(4'h6, 16'h0);
    m.access(1'h1, timer_pkg::OFS_PERIOD_BASE, p);
    m.access(1'h1, 4'h3, 16'h0);
    m.access(1'h1, timer_pkg::OFS_SNAP_BASE, 16'($urandom));
    rd_exp(timer_pkg::OFS_SNAP_BASE, p);
    rd_exp(4'h5, 16'h0);
    m.access(1'h1, timer_pkg::OFS_CONTROL, 16'h0005);
    wait_irq(p + 1);
    rd_exp(timer_pkg::OFS_STATUS, 16'h0001);
    m.access(1'h1, timer_pkg::OFS_SNAP_BASE, 16'h0);
    rd_exp(timer_pkg::OFS_SNAP_BASE, p);
    m.access(1'h1, timer_pkg::OFS_CONTROL, 16'h0);
    check("IRQ_O", 1'h0, irq);
    rd_exp(timer_pkg::OFS_STATUS, 16'h0001);
    m.access(1'h1, timer_pkg::OFS_STATUS, 16'h0);
    m.access(1'h1, timer_pkg::OFS_CONTROL, 16'h0007);
    wait_irq(p + 1);
    m.access(1'h1, timer_pkg::OFS_STATUS, 16'h0);
    m.access(1'h1, timer_pkg::OFS_SNAP_BASE, 16'h0);
    rd_exp(timer_pkg::OFS_STATUS, 16'h0002);
    m.access(1'h1, timer_pkg::OFS_CONTROL, 16'h000d);
    rd_exp(timer_pkg::OFS_CONTROL, 16'h0001);
    rd_exp(timer_pkg::OFS_STATUS, 16'h0);
    m.access(1'h1, 4'h3, 16'h0);
    m.access(1'h1, timer_pkg::OFS_CONTROL, 16'h0004);
    rd_exp(timer_pkg::OFS_STATUS, 16'h0002);
    m.access(1'h1, timer_pkg::OFS_PERIOD_BASE, p);
    rd_exp(timer_pkg::OFS_STATUS, 16'h0);
    repeat (2) @(negedge clk);
    fix_sel <= 1'h1;
    m.access(1'h1, timer_pkg::OFS_PERIOD_BASE, 16'($urandom));
    rd_exp(timer_pkg::OFS_PERIOD_BASE, FIX_PERIOD[15:0]);
    m.access(1'h1, timer_pkg::OFS_CONTROL, 16'h0007);
    wait_irq(int'(FIX_PERIOD) + 1);
    m.access(1'h1, timer_pkg::OFS_CONTROL, 16'h000b);
    rd_exp(timer_pkg::OFS_STATUS, 16'h0003);
    m.access(1'h1, 4'h3, 16'h0);
    rd_exp(timer_pkg::OFS_STATUS, 16'h0003);
    m.access(1'h1, timer_pkg::OFS_CONTROL, 16'h0002);
    check("IRQ_O", 1'h0, irq_f);
    repeat (2) @(negedge clk);
    summarize();
  end
endmodule : testbench
